// File: rtl/nst_pkg.sv
// Package: register map, field layout, reset values and states of the NAND strobe timer
package nst_pkg;
  // =====================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_TIMING   = 8'h00; // timing_addr/data_setup/hold fields
  localparam logic [7:0] REG_CONTROL  = 8'h04; // port_control_one
  localparam logic [7:0] REG_COMMAND  = 8'h08; // Cycle request
  localparam logic [7:0] REG_STATUS   = 8'h0c; // Busy, levels
  localparam logic [7:0] REG_RDDATA   = 8'h10; // Pop captured read byte
  // =====================================================
  // Field positions
  localparam int AS_LSB = 0;  // timing_addr_setup_field [7:0]
  localparam int DS_LSB = 8;  // timing_data_setup_field [15:8]
  localparam int DH_LSB = 16; // timing_data_hold_field [23:16]
  localparam int DLY_LSB = 0; // read_capture_delay [3:0]
  localparam int EDO_BIT = 4; // Extended data out enable
  // Command field: [1:0] kind, [15:8] write byte
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_ADDR  = 2'h1;
  localparam logic [1:0] CMD_READ  = 2'h2;
  // =====================================================
  // Reset values
  localparam logic [7:0] AS_RST  = 8'h00;
  localparam logic [7:0] DS_RST  = 8'h01;
  localparam logic [7:0] DH_RST  = 8'h01;
  localparam logic [3:0] DLY_RST = 4'h8; // Typical for 50 MT/s EDO
  localparam logic [7:0] MIN_DS_DH = 8'h01;
  // Buffer shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 32;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Sequencer states, Gray along the path except the step from ALEH back to IDLE
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_LOW   = 3'b011,
    ST_HIGH  = 3'b010,
    ST_ALEH  = 3'b110
  } nst_state_type;
endpackage : nst_pkg

// File: rtl/nst_fifo.sv
// Synchronous FIFO with valid/ready on both sides, flip-flop storage
module nst_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys,   // System clock
  input  wire logic             nrst,      // Sync reset, active low
  input  wire logic [WIDTH-1:0] in_data,   // Write data
  input  wire logic             in_valid,  // Write request
  output logic                  in_ready,  // Not full
  output logic      [WIDTH-1:0] out_data,  // Head word
  output logic                  out_valid, // Not empty
  input  wire logic             out_ready  // Pop
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  // =====================================================
  // Pointer and count update
  always_comb begin
    push = in_valid && (count != DEPTH[AW:0]);
    pop  = out_ready && (count != '0);
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage needs no reset; guarded by count
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
endmodule : nst_fifo

// File: rtl/nst_timer.sv
// NAND port strobe timing sequencer with AXI4-Lite registers and read FIFO
module nst_timer
  import nst_pkg::*;
(
  input  wire logic        clk_sys,       // System clock, 20 MHz
  input  wire logic        nrst,          // Sync reset, active low
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Byte strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [7:0]  s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready,  // Read data ready
  // NAND pins
  output logic             nand_we_n,     // Write enable, active low
  output logic             nand_re_n,     // Read enable, active low
  output logic             nand_ale,      // Address latch enable
  output logic [7:0]       nand_io_out,   // Data out
  output logic             nand_io_oe_n,  // Data drive enable, low drives
  input  wire logic [7:0]  nand_io_in     // Data in, asynchronous
);
  import nst_pkg::*;

  // =====================================================
  // Register state
  logic [7:0]  as_cnt, ds_cnt, dh_cnt, next_as, next_ds, next_dh;
  logic [3:0]  dly, next_dly;
  logic        edo, next_edo;
  logic        aw_held, w_held, next_aw_held, next_w_held;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0]  bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic        cmd_go;
  logic [1:0]  cmd_kind;
  logic [7:0]  cmd_byte;
  logic        do_write, fifo_pop;
  logic        busy;
  logic        fifo_in_ready, fifo_out_valid, cap_valid;
  logic [7:0]  fifo_out_data, cap_data;

  // Write accepted once both halves are held and no response pending
  assign do_write = aw_held && w_held && !bvalid;

  // =====================================================
  // AXI write path and configuration registers
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_as  = as_cnt;
    next_ds  = ds_cnt;
    next_dh  = dh_cnt;
    next_dly = dly;
    next_edo = edo;
    cmd_go   = 1'b0;
    cmd_kind = w_data[1:0];
    cmd_byte = w_data[15:8];
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      unique case (aw_addr)
        REG_TIMING: begin
          if (w_strb[0]) next_as = w_data[AS_LSB+:8];
          if (w_strb[1]) next_ds = (w_data[DS_LSB+:8] < MIN_DS_DH) ? MIN_DS_DH
                                   : w_data[DS_LSB+:8];
          if (w_strb[2]) next_dh = (w_data[DH_LSB+:8] < MIN_DS_DH) ? MIN_DS_DH
                                   : w_data[DH_LSB+:8];
        end
        REG_CONTROL: begin
          if (w_strb[0]) begin
            next_dly = w_data[DLY_LSB+:4];
            next_edo = w_data[EDO_BIT];
          end
        end
        REG_COMMAND: begin
          // Busy sequencer or full buffer refuses the command
          if (busy || !fifo_in_ready) next_bresp = RESP_SLVERR;
          else cmd_go = 1'b1;
        end
        default: next_bresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      as_cnt  <= AS_RST;
      ds_cnt  <= DS_RST;
      dh_cnt  <= DH_RST;
      dly     <= DLY_RST;
      edo     <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      as_cnt  <= next_as;
      ds_cnt  <= next_ds;
      dh_cnt  <= next_dh;
      dly     <= next_dly;
      edo     <= next_edo;
    end
  end

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;

  // =====================================================
  // AXI read path; reading the data register pops the buffer
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    fifo_pop    = 1'b0;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        REG_TIMING:  next_rdata = {8'h00, dh_cnt, ds_cnt, as_cnt};
        REG_CONTROL: next_rdata = {27'h0, edo, dly};
        REG_COMMAND: next_rdata = 32'h0000_0000;
        REG_STATUS:  next_rdata = {27'h0, nand_ale, nand_re_n, nand_we_n,
                                   fifo_out_valid, busy};
        REG_RDDATA: begin
          next_rdata = {23'h0, fifo_out_valid, fifo_out_data};
          fifo_pop   = fifo_out_valid;
        end
        default: next_rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  // =====================================================
  // Strobe sequencer; counts are clk_sys periods
  nst_state_type state, next_state;
  logic [7:0] cnt, next_cnt;
  logic [1:0] kind, next_kind;
  logic [7:0] obyte, next_obyte;
  logic       we_n, re_n, ale, oe_n;
  logic       next_we_n, next_re_n, next_ale, next_oe_n;

  assign busy = (state != ST_IDLE);

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_kind  = kind;
    next_obyte = obyte;
    next_we_n  = we_n;
    next_re_n  = re_n;
    next_ale   = ale;
    next_oe_n  = oe_n;
    unique case (state)
      ST_IDLE: begin
        if (cmd_go) begin
          next_kind  = cmd_kind;
          next_obyte = cmd_byte;
          next_ale   = (cmd_kind == CMD_ADDR);
          next_oe_n  = (cmd_kind == CMD_READ);
          next_cnt   = as_cnt;
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // AS counts, plus this one: ALE leads strobe by AS+1 periods
        if (cnt == 8'h00) begin
          next_we_n  = (kind == CMD_READ);
          next_re_n  = (kind != CMD_READ);
          next_cnt   = ds_cnt - 8'h01;
          next_state = ST_LOW;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      ST_LOW: begin
        if (cnt == 8'h00) begin
          next_we_n  = 1'b1;
          next_re_n  = 1'b1;
          next_cnt   = dh_cnt - 8'h01;
          next_state = ST_HIGH;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      ST_HIGH: begin
        if (cnt == 8'h00) begin
          // Extra period of ALE hold beyond DH
          next_state = (kind == CMD_ADDR) ? ST_ALEH : ST_IDLE;
          next_oe_n  = (kind == CMD_ADDR) ? oe_n : 1'b1;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      ST_ALEH: begin
        next_ale   = 1'b0;
        next_oe_n  = 1'b1;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state <= ST_IDLE;
      cnt   <= 8'h00;
      kind  <= CMD_WRITE;
      obyte <= 8'h00;
      we_n  <= 1'b1;
      re_n  <= 1'b1;
      ale   <= 1'b0;
      oe_n  <= 1'b1;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      kind  <= next_kind;
      obyte <= next_obyte;
      we_n  <= next_we_n;
      re_n  <= next_re_n;
      ale   <= next_ale;
      oe_n  <= next_oe_n;
    end
  end

  assign nand_we_n    = we_n;
  assign nand_re_n    = re_n;
  assign nand_ale     = ale;
  assign nand_io_out  = obyte;
  assign nand_io_oe_n = oe_n;

  // =====================================================
  // Read capture: synchronised bus, tapped delay line of read-enable
  logic [7:0]  io_meta, io_sync;
  logic [15:0] re_line, next_re_line;
  logic        re_dly, next_re_dly;
  logic        cap_edo, cap_plain;

  always_comb begin
    next_re_line = {re_line[14:0], re_n};
    next_re_dly  = re_line[dly];
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      io_meta  <= 8'h00;
      io_sync  <= 8'h00;
      re_line  <= 16'hffff;
      re_dly   <= 1'b1;
    end else begin
      io_meta  <= nand_io_in;
      io_sync  <= io_meta;
      re_line  <= next_re_line;
      re_dly   <= next_re_dly;
    end
  end

  // Delay is in clock taps, coarse; a board with long flight needs more taps
  // Edge seen at the tap itself, a period early, so io_sync still holds the byte
  assign cap_edo   = edo && kind == CMD_READ && next_re_dly && !re_dly;
  // Non-EDO samples at the end of the read-enable low phase
  assign cap_plain = !edo && state == ST_LOW && kind == CMD_READ && cnt == 8'h00;
  assign cap_valid = cap_edo || cap_plain;
  assign cap_data  = io_sync;

  nst_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_rd_fifo (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .in_data   (cap_data),
    .in_valid  (cap_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );
endmodule : nst_timer

// File: dv/nst_timer_properties.sv
// Checker of strobe ordering and widths at the NAND timer pins
module nst_timer_properties (
  input wire logic clk_sys,     // System clock
  input wire logic nrst,        // Sync reset, active low
  input wire logic nand_we_n,   // Write strobe
  input wire logic nand_re_n,   // Read strobe
  input wire logic nand_ale,    // Address latch enable
  input wire logic nand_io_oe_n // Data drive enable, low drives
);
  timeunit 1ns;
  timeprecision 1ns;
  // =========
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // =========
  // Strobes
  property p_strobe_excl;
    !(!nand_we_n && !nand_re_n);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl) else $error("both strobes low");

  property p_we_drives;
    !nand_we_n |-> !nand_io_oe_n;
  endproperty
  a_we_drives: assert property (p_we_drives) else $error("write strobe without data");

  property p_re_floats;
    !nand_re_n |-> nand_io_oe_n;
  endproperty
  a_re_floats: assert property (p_re_floats) else $error("io driven during read");

  // Hold count is never below one period, so a strobe stays high a cycle
  property p_hold_min;
    $rose(nand_we_n) || $rose(nand_re_n) |=> nand_we_n && nand_re_n;
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("hold shorter than one clock");

  // =========
  // Latch enable framing
  property p_ale_setup;
    $rose(nand_ale) |-> nand_we_n && nand_re_n;
  endproperty
  a_ale_setup: assert property (p_ale_setup) else $error("ale setup too short");

  property p_ale_hold;
    $rose(nand_we_n) && nand_ale |=> nand_ale;
  endproperty
  a_ale_hold: assert property (p_ale_hold) else $error("ale hold too short");

  property p_ale_unit;
    $fell(nand_ale) |-> $past(nand_we_n) && $past(nand_re_n, 1);
  endproperty
  a_ale_unit: assert property (p_ale_unit) else $error("ale dropped in a strobe");
endmodule : nst_timer_properties

bind nst_timer nst_timer_properties i_props (.clk_sys, .nrst, .nand_we_n, .nand_re_n,
  .nand_ale, .nand_io_oe_n);

// File: dv/nst_flash_model.sv
// Behavioural flash: answers each read strobe with a counting byte
module nst_flash_model #(
  parameter int T_ACC = 16, // Access time after read strobe falls, ns
  parameter int T_OH  = 15  // Output hold after read strobe rises, ns
) (
  input  wire logic       nand_re_n, // Read strobe
  output logic      [7:0] nand_io_in // Byte to the controller
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] count = 8'h00;
  initial nand_io_in = 8'h5a;
  // =========
  // Byte appears one access time after the strobe falls
  always @(negedge nand_re_n) begin
    count = count + 8'h01;
    #(T_ACC) nand_io_in = 8'ha0 + count;
  end
  // Lines float after hold; inverse shown so stale data never passes
  always @(posedge nand_re_n) begin
    #(T_OH) nand_io_in = ~nand_io_in;
  end
endmodule : nst_flash_model

// File: dv/tb_top.sv
// Testbench of the NAND strobe timer: registers, strobe widths, read buffer
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import nst_pkg::*;
  logic        clk_sys = 1'b0, nrst = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        nand_we_n, nand_re_n, nand_ale, nand_io_oe_n;
  logic [7:0]  nand_io_out, nand_io_in, wbyte;
  int          fails = 0, checked = 0, k = 0;
  int          we_cnt = 0, re_cnt = 0, we_w = 0, re_w = 0;
  int          aa = 0, ab = 0, hit = 0, ale_su = 0, ale_ho = 0;
  int          t_as[4] = '{0, 0, 2, 5};
  int          t_ds[4] = '{1, 3, 4, 6};
  int          t_dh[4] = '{1, 1, 3, 2};

  // Free-running system clock, 50 ns
  always #25 clk_sys = ~clk_sys;

  nst_timer i_dut (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nand_we_n, .nand_re_n,
    .nand_ale, .nand_io_out, .nand_io_oe_n, .nand_io_in);

  nst_flash_model i_flash (.nand_re_n, .nand_io_in);

  // =========
  // Pin monitor: strobe widths and latch framing in clock periods
  always @(posedge clk_sys) begin
    if (!nand_we_n) we_cnt <= we_cnt + 1;
    else if (we_cnt != 0) begin
      we_w <= we_cnt;
      we_cnt <= 0;
    end
    if (!nand_re_n) re_cnt <= re_cnt + 1;
    else if (re_cnt != 0) begin
      re_w <= re_cnt;
      re_cnt <= 0;
    end
    if (!nand_we_n && !nand_io_oe_n) wbyte <= nand_io_out;
    if (nand_ale) begin
      if (!nand_we_n) hit <= 1;
      else if (hit != 0) ab <= ab + 1;
      else aa <= aa + 1;
    end else if (aa != 0) begin
      ale_su <= aa;
      ale_ho <= ab;
      aa <= 0;
      ab <= 0;
      hit <= 0;
    end
  end

  // =========
  // Bus master and comparison tasks
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check_word

  task automatic end_of_test();
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // Address and data offered together; each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // Command, then poll busy; two spare clocks let the monitor settle
  task automatic cmd(input logic [1:0] kind, input logic [7:0] b);
    axi_wr(REG_COMMAND, {16'h0, b, 6'h0, kind}, rs);
    check_word(32'(rs), 32'(RESP_OKAY), "command response");
    do axi_rd(REG_STATUS, rd, rs);
    while (rd[0] !== 1'b0);
    repeat (2) @(posedge clk_sys);
  endtask : cmd

  // Pops one captured byte and compares with the flash pattern
  task automatic pop_byte();
    k++;
    axi_rd(REG_RDDATA, rd, rs);
    check_word(rd, {23'h0, 1'b1, 8'(8'ha0 + k)}, "read byte");
  endtask : pop_byte

  // =========
  // Test sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    axi_rd(REG_TIMING, rd, rs);
    check_word(rd, {8'h00, DH_RST, DS_RST, AS_RST}, "timing reset");
    axi_rd(REG_CONTROL, rd, rs);
    check_word(rd & 32'h1f, 32'(DLY_RST), "control reset");
    axi_rd(REG_STATUS, rd, rs);
    check_word(rd, 32'h0000000c, "status reset");
    axi_rd(8'h14, rd, rs);
    check_word({rd[29:0], rs}, {30'h0, RESP_SLVERR}, "unmapped read");
    axi_wr(8'h14, 32'h1, rs);
    check_word(32'(rs), 32'(RESP_SLVERR), "unmapped write");
    axi_wr(REG_TIMING, 32'h0, rs);
    axi_rd(REG_TIMING, rd, rs);
    check_word(rd, 32'h00010100, "zero counts clamp");
    // Only the data setup byte lane is enabled
    s_axi_wstrb <= 4'h2;
    axi_wr(REG_TIMING, 32'h00ff07ff, rs);
    s_axi_wstrb <= 4'hf;
    axi_rd(REG_TIMING, rd, rs);
    check_word(rd, 32'h00010700, "byte strobe write");
    for (int i = 0; i < 4; i++) begin
      axi_wr(REG_TIMING, {8'h00, 8'(t_dh[i]), 8'(t_ds[i]), 8'(t_as[i])}, rs);
      cmd(CMD_ADDR, 8'(8'h30 + i));
      check_word(32'(ale_su), 32'(t_as[i] + 1), "ale setup");
      check_word(32'(ale_ho), 32'(t_dh[i] + 1), "ale hold");
      check_word({24'h0, wbyte}, 32'(8'h30 + i), "address byte");
      cmd(CMD_WRITE, 8'(8'hc0 + i));
      check_word(32'(we_w), 32'(t_ds[i]), "write low");
      check_word({24'h0, wbyte}, 32'(8'hc0 + i), "write byte");
      if (t_ds[i] > 2) begin
        cmd(CMD_READ, 8'h00);
        check_word(32'(re_w), 32'(t_ds[i]), "read low");
        pop_byte();
      end
    end
    // Second command while the first runs is refused
    axi_wr(REG_COMMAND, {30'h0, CMD_READ}, rs);
    check_word(32'(rs), 32'(RESP_OKAY), "first command");
    axi_wr(REG_COMMAND, {30'h0, CMD_READ}, rs);
    check_word(32'(rs), 32'(RESP_SLVERR), "busy refusal");
    repeat (30) @(posedge clk_sys);
    pop_byte();
    // Fill the buffer until it refuses, then drain it empty
    axi_wr(REG_TIMING, 32'h00010300, rs);
    for (int i = 0; i < FIFO_DEPTH; i++) cmd(CMD_READ, 8'h00);
    axi_wr(REG_COMMAND, {30'h0, CMD_READ}, rs);
    check_word(32'(rs), 32'(RESP_SLVERR), "full refusal");
    for (int i = 0; i < FIFO_DEPTH; i++) pop_byte();
    axi_rd(REG_RDDATA, rd, rs);
    check_word(32'(rd[8]), 32'h0, "empty buffer");
    // Delayed-strobe capture; no board flight here, so the shortest delay suits
    axi_wr(REG_CONTROL, 32'h10, rs);
    axi_rd(REG_CONTROL, rd, rs);
    check_word(rd & 32'h1f, 32'h10, "control write");
    cmd(CMD_READ, 8'h00);
    pop_byte();
    end_of_test();
  end

  // Watchdog, far beyond the thousand or so clocks the tests need
  initial begin
    #2000000;
    fails++;
    end_of_test();
  end
endmodule : tb_top
